//--- rtl/osc_ctrl.sv
// Oscillator select, write-protected control register and failure monitor top
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Unlock by writing E7H then 18H
// - Next write stored, then register relocks
// - Writes without full unlock are ignored
// - Keys ordered; other register accesses tolerated
// - Failure enables accepted after source write
// - Precision oscillator off only by software
// - Primary failure: event, switch to watchdog
// - No switch if watchdog selected/disabled
// - Primary failure below about one kilohertz
// - Watchdog failure: event, no source change
// - After watchdog failure, no primary detection
// - Watchdog failure after 8004 system clocks
// - 32 kHz clock to timers, runs halted
// - Crystal enable takes over crystal pins
// - Three-bit source select, reserved codes
// - Control bits 7 to 3 are enables
// - Nothing running, no detection: device stops
module osc_ctrl #(
  parameter int unsigned ADDR_W     = 16,                   // Bus address width
  parameter int unsigned PRIM_LIMIT = osc_pkg::PRIM_FAIL_CYC, // Primary timeout
  parameter int unsigned WDT_LIMIT  = osc_pkg::WDT_FAIL_CNT   // Watchdog timeout
) (
  input  wire logic              aclk,            // Bus clock, 125 MHz
  input  wire logic              aresetn,         // Sync reset, active low
  input  wire logic [ADDR_W-1:0] awaddr,          // Write address
  input  wire logic              awvalid,         // Write address valid
  output logic                   awready,         // Write address ready
  input  wire logic [31:0]       wdata,           // Write data
  input  wire logic [3:0]        wstrb,           // Write byte enables
  input  wire logic              wvalid,          // Write data valid
  output logic                   wready,          // Write data ready
  output logic [1:0]             bresp,           // Write answer
  output logic                   bvalid,          // Write answer valid
  input  wire logic              bready,          // Write answer ready
  input  wire logic [ADDR_W-1:0] araddr,          // Read address
  input  wire logic              arvalid,         // Read address valid
  output logic                   arready,         // Read address ready
  output logic [31:0]            rdata,           // Read data
  output logic [1:0]             rresp,           // Read answer
  output logic                   rvalid,          // Read answer valid
  input  wire logic              rready,          // Read answer ready
  input  wire logic              sys_tick,        // Edge of system clock source
  input  wire logic              wdt_tick,        // Edge of watchdog oscillator
  input  wire logic              sec_osc_clk,     // 32 kHz secondary oscillator
  output logic                   ipo_en,          // Precision oscillator enable
  output logic                   xtal_en,         // Crystal oscillator enable
  output logic                   xtal_pin_own,    // Crystal owns both crystal pins
  output logic                   wdt_osc_en,      // Watchdog oscillator enable
  output logic [2:0]             sys_clk_sel,     // System clock source code
  output logic                   timer_periph_clk, // Peripheral clock to timers
  output logic                   fail_event,      // Non-maskable event pulse
  output logic                   dev_halted       // Device has stopped
);
  // Address must reach the control register byte address
  if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_addr_w
    $error("osc_ctrl: ADDR_W must be 14 to 32");
  end

  // ==========================================================
  // Decoding helpers
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
    addr_hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  // Is the selected source one that can actually run
  function automatic logic src_running(input logic [7:0] c);
    case (c[osc_pkg::SEL_MSB:0])
      osc_pkg::SEL_IPO:  src_running = c[osc_pkg::IPO_EN_BIT];
      osc_pkg::SEL_XTAL: src_running = c[osc_pkg::XTAL_EN_BIT];
      osc_pkg::SEL_WDT:  src_running = c[osc_pkg::WDT_EN_BIT];
      osc_pkg::SEL_EXT:  src_running = 1'b1;
      default:           src_running = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // State
  logic [ADDR_W-1:0]  awaddr_ff;    // Held write address
  logic               aw_held_ff;   // Write address taken
  logic [7:0]         wbyte_ff;     // Held low data byte
  logic               wlane_ff;     // Low byte lane enabled
  logic               w_held_ff;    // Write data taken
  logic [7:0]         ctl0_ff;      // Control register 0
  osc_pkg::osc_lock_t lock_ff;      // Unlock sequencer
  logic               pfail_st_ff;  // Sticky primary failure
  logic               wfail_st_ff;  // Sticky watchdog failure
  logic               wdt_dead_ff;  // Watchdog failed, until reset
  logic               halted_ff;    // Stopped, until reset
  logic               prim_fail;    // Monitor primary pulse
  logic               wdt_fail;     // Monitor watchdog pulse

  logic wr_go;     // Address and data both present
  logic hit_ctl;   // Write targets control register
  logic hit_stat;  // Write targets status register
  logic ctl_wr;    // Real byte write to control register
  logic recover;   // Automatic switch to watchdog
  assign wr_go    = aw_held_ff && w_held_ff && !bvalid;
  assign hit_ctl  = addr_hit(awaddr_ff, osc_pkg::CTL0_IDX);
  assign hit_stat = addr_hit(awaddr_ff, osc_pkg::STAT_IDX);
  assign ctl_wr   = wr_go && hit_ctl && wlane_ff;
  // Switch only when the watchdog can take over and is not already in use
  assign recover  = prim_fail && ctl0_ff[osc_pkg::WDT_EN_BIT]
                    && ctl0_ff[osc_pkg::SEL_MSB:0] != osc_pkg::SEL_WDT;

  // ==========================================================
  // Write channels: address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= '0;
      awready    <= 1'b1;
      w_held_ff  <= 1'b0;
      wbyte_ff   <= 8'h00;
      wlane_ff   <= 1'b0;
      wready     <= 1'b1;
    end else begin
      if (awvalid && awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= awaddr;
        awready    <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_ff <= 1'b1;
        wbyte_ff  <= wdata[7:0];
        wlane_ff  <= wstrb[0];
        wready    <= 1'b0;
      end
      // Reopen both channels once the answer is taken
      if (bvalid && bready) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        awready    <= 1'b1;
        wready     <= 1'b1;
      end
    end
  end

  // Write answer, one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= osc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= (hit_ctl || hit_stat) ? osc_pkg::RESP_OKAY : osc_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Read channel: answer one cycle after address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= osc_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= osc_pkg::RESP_OKAY;
      if (addr_hit(araddr, osc_pkg::CTL0_IDX)) begin
        rdata <= {24'h00_0000, ctl0_ff};
      end else if (addr_hit(araddr, osc_pkg::STAT_IDX)) begin
        rdata <= {28'h000_0000, halted_ff, lock_ff == osc_pkg::LK_OPEN,
                  wfail_st_ff, pfail_st_ff};
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= osc_pkg::RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // ==========================================================
  // Unlock sequencer; only writes to the control register move it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_ff <= osc_pkg::LK_LOCKED;
    end else if (ctl_wr) begin
      case (lock_ff)
        osc_pkg::LK_LOCKED: lock_ff <= (wbyte_ff == osc_pkg::UNLOCK_KEY1) ?
                                       osc_pkg::LK_HALF : osc_pkg::LK_LOCKED;
        osc_pkg::LK_HALF:   lock_ff <= (wbyte_ff == osc_pkg::UNLOCK_KEY2) ?
                                       osc_pkg::LK_OPEN : osc_pkg::LK_LOCKED;
        osc_pkg::LK_OPEN:   lock_ff <= osc_pkg::LK_LOCKED;
        default:            lock_ff <= osc_pkg::LK_LOCKED;
      endcase
    end
  end

  // Control register: stores only when open; recovery overrides the source
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl0_ff <= osc_pkg::CTL0_RESET;
    end else begin
      if (ctl_wr && lock_ff == osc_pkg::LK_OPEN) begin
        // Enables, including re-armed detection, land as written
        ctl0_ff[7:3] <= wbyte_ff[7:3];
        // Reserved source codes leave the running source alone
        if (wbyte_ff[2:0] == osc_pkg::SEL_IPO || wbyte_ff[2:0] == osc_pkg::SEL_XTAL
            || wbyte_ff[2:0] == osc_pkg::SEL_WDT
            || wbyte_ff[2:0] == osc_pkg::SEL_EXT) begin
          ctl0_ff[2:0] <= wbyte_ff[2:0];
        end
      end
      if (recover) begin
        ctl0_ff[osc_pkg::SEL_MSB:0] <= osc_pkg::SEL_WDT;
      end
    end
  end

  // ==========================================================
  // Failure monitor; a dead watchdog disarms primary detection
  osc_fail_mon #(
    .PRIM_LIMIT (PRIM_LIMIT),
    .WDT_LIMIT  (WDT_LIMIT)
  ) u_mon (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .sys_tick  (sys_tick),
    .wdt_tick  (wdt_tick),
    .prim_en   (ctl0_ff[osc_pkg::PFD_EN_BIT] && !wdt_dead_ff),
    .wdt_en    (ctl0_ff[osc_pkg::WFD_EN_BIT]),
    .prim_fail (prim_fail),
    .wdt_fail  (wdt_fail)
  );

  // Event pulse; a watchdog failure never touches the source select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fail_event <= 1'b0;
    end else begin
      fail_event <= prim_fail || wdt_fail;
    end
  end

  // Sticky flags; a new event wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pfail_st_ff <= 1'b0;
      wfail_st_ff <= 1'b0;
      wdt_dead_ff <= 1'b0;
    end else begin
      if (wr_go && hit_stat && wlane_ff) begin
        pfail_st_ff <= pfail_st_ff && !wbyte_ff[osc_pkg::ST_PFAIL_BIT];
        wfail_st_ff <= wfail_st_ff && !wbyte_ff[osc_pkg::ST_WFAIL_BIT];
      end
      if (prim_fail) begin
        pfail_st_ff <= 1'b1;
      end
      if (wdt_fail) begin
        wfail_st_ff <= 1'b1;
        wdt_dead_ff <= 1'b1;
      end
    end
  end

  // Stopped device: only a reset brings it back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halted_ff <= 1'b0;
    end else if (!src_running(ctl0_ff) && !ctl0_ff[osc_pkg::PFD_EN_BIT]
                 && !ctl0_ff[osc_pkg::WFD_EN_BIT]) begin
      halted_ff <= 1'b1;
    end
  end

  // Peripheral clock goes to timers only and ignores any halt state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_periph_clk <= 1'b0;
    end else begin
      timer_periph_clk <= sec_osc_clk;
    end
  end

  // ==========================================================
  // Register-sourced outputs
  assign ipo_en       = ctl0_ff[osc_pkg::IPO_EN_BIT];
  assign xtal_en      = ctl0_ff[osc_pkg::XTAL_EN_BIT];
  assign xtal_pin_own = ctl0_ff[osc_pkg::XTAL_EN_BIT];
  assign wdt_osc_en   = ctl0_ff[osc_pkg::WDT_EN_BIT];
  assign sys_clk_sel  = ctl0_ff[osc_pkg::SEL_MSB:0];
  assign dev_halted   = halted_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_open_relocks: assert property (ctl_wr && lock_ff == osc_pkg::LK_OPEN
    |=> lock_ff == osc_pkg::LK_LOCKED)
    else $error("register did not relock after stored write");
  a_locked_ignore: assert property (ctl_wr && lock_ff != osc_pkg::LK_OPEN && !recover
    |=> ctl0_ff == $past(ctl0_ff))
    else $error("locked write changed control register");
  a_key_order: assert property (ctl_wr && lock_ff == osc_pkg::LK_LOCKED
    && wbyte_ff == osc_pkg::UNLOCK_KEY2 |=> lock_ff == osc_pkg::LK_LOCKED)
    else $error("second key unlocked out of order");
  a_other_regs: assert property (wr_go && !hit_ctl |=> lock_ff == $past(lock_ff))
    else $error("other register write moved lock state");
  a_recover_sel: assert property (recover && !ctl_wr
    |=> ctl0_ff[2:0] == 3'h3 && fail_event)
    else $error("primary failure did not switch to watchdog");
  a_no_recover: assert property (prim_fail && !ctl_wr && !ctl0_ff[5]
    |=> ctl0_ff[2:0] == $past(ctl0_ff[2:0]))
    else $error("switch happened with watchdog disabled");
  a_wdt_keep: assert property (wdt_fail && !ctl_wr && !recover
    |=> fail_event && ctl0_ff[2:0] == $past(ctl0_ff[2:0]))
    else $error("watchdog failure changed source or gave no event");
  a_dead_block: assert property (wdt_dead_ff ##1 wdt_dead_ff |-> !prim_fail)
    else $error("primary failure seen after watchdog failure");
  a_halt_sticky: assert property (halted_ff |=> halted_ff [*2])
    else $error("stopped device resumed without reset");

  c_unlock_store: cover property (ctl_wr && lock_ff == osc_pkg::LK_OPEN);
  c_recover: cover property (recover);
  c_wdt_fail: cover property (wdt_fail ##[1:20] bvalid);
endmodule
`default_nettype wire

//--- rtl/osc_pkg.sv
// Package: register map, field layout, keys and timing for the oscillator control block
package osc_pkg;
  // ==========================================================
  // Register indices (byte address is index times four)
  localparam logic [11:0] CTL0_IDX       = 12'hF86; // Control register 0
  localparam logic [11:0] STAT_IDX       = 12'hF88; // Status register
  localparam logic [7:0]  CTL0_RESET     = 8'hA0;   // Precision and watchdog osc on
  // ==========================================================
  // Control register 0 fields
  localparam int          IPO_EN_BIT     = 7;       // Precision oscillator enable
  localparam int          XTAL_EN_BIT    = 6;       // Crystal oscillator enable
  localparam int          WDT_EN_BIT     = 5;       // Watchdog oscillator enable
  localparam int          PFD_EN_BIT     = 4;       // Primary failure detect enable
  localparam int          WFD_EN_BIT     = 3;       // Watchdog failure detect enable
  localparam int          SEL_MSB        = 2;       // Clock source select, top bit
  // ==========================================================
  // Status register fields
  localparam int          ST_PFAIL_BIT   = 0;       // Primary failure seen
  localparam int          ST_WFAIL_BIT   = 1;       // Watchdog failure seen
  localparam int          ST_OPEN_BIT    = 2;       // Unlocked, next write lands
  localparam int          ST_HALT_BIT    = 3;       // Device stopped
  // ==========================================================
  // Unlock keys and source codes
  localparam logic [7:0]  UNLOCK_KEY1    = 8'hE7;   // First key
  localparam logic [7:0]  UNLOCK_KEY2    = 8'h18;   // Second key
  localparam logic [2:0]  SEL_IPO        = 3'h0;    // Precision oscillator
  localparam logic [2:0]  SEL_XTAL       = 3'h2;    // Crystal or external RC
  localparam logic [2:0]  SEL_WDT        = 3'h3;    // Watchdog oscillator
  localparam logic [2:0]  SEL_EXT        = 3'h4;    // External clock pin
  // ==========================================================
  // Timing
  localparam int          CLK_PERIOD_NS  = 8;       // Bus clock period
  localparam int          PRIM_FAIL_US   = 1000;    // Primary threshold period
  localparam int          PRIM_FAIL_CYC  = PRIM_FAIL_US * 1000 / CLK_PERIOD_NS;
  localparam int          WDT_FAIL_CNT   = 8004;    // System clocks without wdt edge
  // ==========================================================
  // Bus answers and lock states
  localparam logic [1:0]  RESP_OKAY      = 2'h0;    // Normal answer
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;    // Unmapped address
  typedef enum logic [2:0] {
    LK_LOCKED = 3'b001,                              // Waiting for first key
    LK_HALF   = 3'b010,                              // First key seen
    LK_OPEN   = 3'b100                               // Next write is stored
  } osc_lock_t;
endpackage

//--- rtl/osc_fail_mon.sv
// Clock failure monitor: primary clock timeout and watchdog clock timeout
`timescale 1ns/100ps
`default_nettype none
module osc_fail_mon #(
  parameter int unsigned PRIM_LIMIT = osc_pkg::PRIM_FAIL_CYC, // Bus clocks per sys edge
  parameter int unsigned WDT_LIMIT  = osc_pkg::WDT_FAIL_CNT   // Sys edges per wdt edge
) (
  input  wire logic aclk,      // Bus clock
  input  wire logic aresetn,   // Sync reset, active low
  input  wire logic sys_tick,  // Edge of selected system clock
  input  wire logic wdt_tick,  // Edge of watchdog oscillator
  input  wire logic prim_en,   // Primary detection armed
  input  wire logic wdt_en,    // Watchdog detection armed
  output logic      prim_fail, // One-cycle primary failure pulse
  output logic      wdt_fail   // One-cycle watchdog failure pulse
);
  localparam int PW = $clog2(PRIM_LIMIT + 1); // Primary counter width
  localparam int WW = $clog2(WDT_LIMIT + 1);  // Watchdog counter width
  localparam logic [PW-1:0] P_LIM = PW'(PRIM_LIMIT);
  localparam logic [WW-1:0] W_LIM = WW'(WDT_LIMIT);

  // Counters of one make a pulse after any single cycle without an edge, which is meaningless
  if (PRIM_LIMIT < 2 || WDT_LIMIT < 2) begin : g_bad_limit
    $error("osc_fail_mon: limits must be at least 2");
  end

  logic [PW-1:0] prim_cnt_ff; // Bus clocks since last system edge
  logic [WW-1:0] wdt_cnt_ff;  // System edges since last wdt edge

  // ==========================================================
  // Primary: a gap longer than the threshold period is a failure
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prim_cnt_ff <= '0;
      prim_fail   <= 1'b0;
    end else begin
      prim_fail <= 1'b0;
      if (!prim_en || sys_tick) begin
        prim_cnt_ff <= '0;
      end else if (prim_cnt_ff != P_LIM) begin
        // Count saturates so one outage gives one pulse
        prim_cnt_ff <= prim_cnt_ff + 1'b1;
        prim_fail   <= (prim_cnt_ff == P_LIM - 1'b1);
      end
    end
  end

  // ==========================================================
  // Watchdog: counts system clocks, not bus clocks, so slow clocks detect slowly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_cnt_ff <= '0;
      wdt_fail   <= 1'b0;
    end else begin
      wdt_fail <= 1'b0;
      if (!wdt_en || wdt_tick) begin
        wdt_cnt_ff <= '0;
      end else if (sys_tick && wdt_cnt_ff != W_LIM) begin
        wdt_cnt_ff <= wdt_cnt_ff + 1'b1;
        wdt_fail   <= (wdt_cnt_ff == W_LIM - 1'b1);
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/tb.sv
// Testbench: register protection, clock select and failure monitor scenarios
`timescale 1ns/100ps
`default_nettype none
module tb;
  // ==========================================================
  // Addresses, nets and bookkeeping
  localparam logic [15:0] A_CTL = 16'h3E18;              // Control 0, index times four
  localparam logic [15:0] A_ST  = 16'h3E20;              // Status register
  localparam logic [15:0] A_BAD = 16'h0040;              // Nothing mapped here
  logic        aclk = 1'b0;                              // Bus clock
  logic        aresetn = 1'b0;                           // Sync reset, active low
  logic [15:0] awaddr = 16'h0, araddr = 16'h0;           // Bus addresses
  logic [31:0] wdata = 32'h0;                            // Write data
  logic [3:0]  wstrb = 4'hF;                             // All byte lanes on
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid; // Slave handshakes
  logic [1:0]  bresp, rresp;                             // Answers
  logic [31:0] rdata;                                    // Read data
  logic        sys_tick = 1'b0, wdt_tick = 1'b0, sec_osc_clk = 1'b0; // Clock edge inputs
  logic        sys_run = 1'b0, wdt_run = 1'b0;           // Source oscillators alive
  logic [3:0]  cnt = 4'h0;                               // Tick pacing
  logic        ipo_en, xtal_en, xtal_pin_own, wdt_osc_en, timer_periph_clk, fail_event, dev_halted;
  logic [2:0]  sys_clk_sel;                              // Selected source
  int          err_total = 0, checked = 0;               // Mismatches and comparisons
  // ==========================================================
  // Device; short limits keep the failure runs brief
  osc_ctrl #(.ADDR_W(16), .PRIM_LIMIT(50), .WDT_LIMIT(20)) i_osc_ctrl (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sys_tick(sys_tick),
    .wdt_tick(wdt_tick), .sec_osc_clk(sec_osc_clk), .ipo_en(ipo_en), .xtal_en(xtal_en),
    .xtal_pin_own(xtal_pin_own), .wdt_osc_en(wdt_osc_en), .sys_clk_sel(sys_clk_sel),
    .timer_periph_clk(timer_periph_clk), .fail_event(fail_event), .dev_halted(dev_halted));
  // ==========================================================
  // Clock and tick sources; sys every 4 cycles, wdt every 8, 32 kHz stand-in
  initial begin
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cnt <= cnt + 4'h1;
    sys_tick <= sys_run && (cnt[1:0] == 2'h0);
    wdt_tick <= wdt_run && (cnt[2:0] == 3'h0);
    sec_osc_clk <= cnt[3];
  end
  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Reset held two cycles; detectors and tick sources restarted
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    sys_run <= 1'b1;
    wdt_run <= 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // Write: AW and W offered together, each dropped when taken, B awaited
  task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !b_t; n++) begin
      @(negedge aclk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
    if (!b_t) err_total++;
  endtask
  // Read: AR held until taken, R awaited with rready high
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    r_t = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !r_t; n++) begin
      @(negedge aclk);
      ar_t = arvalid & arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
    if (!r_t) err_total++;
  endtask
  // Both keys then the real value
  task automatic unlock_wr(input logic [7:0] d);
    logic [1:0] r;
    wr(A_CTL, 8'hE7, r);
    wr(A_CTL, 8'h18, r);
    wr(A_CTL, d, r);
  endtask
  // Cycles until a failure pulse, bounded
  task automatic wait_evt(input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(negedge aclk);
      if (fail_event === 1'b1) break;
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_lock();
    logic [31:0] d;
    logic [1:0]  r;
    do_reset();
    rd(A_CTL, d, r);
    chk(d, 32'hA0);
    chk({ipo_en, wdt_osc_en, sys_clk_sel}, 5'h18);
    wr(A_CTL, 8'h5A, r);
    wr(A_CTL, 8'h18, r);
    wr(A_CTL, 8'hE7, r);
    wr(A_CTL, 8'h00, r);
    rd(A_CTL, d, r);
    chk(d, 32'hA0);
    wr(A_CTL, 8'hE7, r);
    wr(A_BAD, 8'h11, r);
    chk(r, 2'h2);
    rd(A_ST, d, r);
    chk(d, 32'h0);
    wr(A_CTL, 8'h18, r);
    // Masked byte lane: neither stored nor relocking
    wstrb <= 4'hE;
    wr(A_CTL, 8'h5A, r);
    wstrb <= 4'hF;
    rd(A_ST, d, r);
    chk(d, 32'h4);
    rd(A_BAD, d, r);
    chk(d, 32'h0);
    chk(r, 2'h2);
    wr(A_CTL, 8'hE2, r);
    rd(A_CTL, d, r);
    chk(d, 32'hE2);
    chk({ipo_en, xtal_en, xtal_pin_own, sys_clk_sel}, 6'h3A);
    wr(A_CTL, 8'h00, r);
    rd(A_CTL, d, r);
    chk(d, 32'hE2);
    unlock_wr(8'hA5);
    rd(A_CTL, d, r);
    chk(d & 32'h07, 32'h02);
    wr(A_CTL, 8'hE7, r);
    do_reset();
    wr(A_CTL, 8'h18, r);
    wr(A_CTL, 8'h00, r);
    rd(A_CTL, d, r);
    chk(d, 32'hA0);
    $display("test lock done");
  endtask
  task automatic t_prim();
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    do_reset();
    unlock_wr(8'hB0);
    sys_run <= 1'b0;
    wait_evt(120, n);
    chk(n >= 45 && n <= 60, 1'b1);
    chk(sys_clk_sel, 3'h3);
    rd(A_ST, d, r);
    chk(d & 32'h1, 32'h1);
    do_reset();
    unlock_wr(8'h90);
    sys_run <= 1'b0;
    wait_evt(120, n);
    chk(fail_event, 1'b1);
    chk(sys_clk_sel, 3'h0);
    $display("test primary done");
  endtask
  task automatic t_wdt();
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    do_reset();
    unlock_wr(8'hA8);
    wdt_run <= 1'b0;
    wait_evt(200, n);
    chk(n >= 70 && n <= 95, 1'b1);
    chk(sys_clk_sel, 3'h0);
    rd(A_ST, d, r);
    chk(d & 32'h2, 32'h2);
    unlock_wr(8'hB0);
    sys_run <= 1'b0;
    wait_evt(150, n);
    chk(n, 150);
    chk(sys_clk_sel, 3'h0);
    $display("test watchdog done");
  endtask
  task automatic t_halt();
    logic prev;
    do_reset();
    unlock_wr(8'h02);
    repeat (3) @(negedge aclk);
    chk(dev_halted, 1'b1);
    for (int i = 0; i < 40; i++) begin
      prev = sec_osc_clk;
      @(negedge aclk);
      chk(timer_periph_clk, prev);
    end
    $display("test halt done");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    t_lock();
    t_prim();
    t_wdt();
    t_halt();
    give_verdict();
  end
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
